// ===== rtl/smat_regs.svh
/*
  Constants for the static address table: entry image bit positions for
  host reads and writes, table geometry, indirect command codes.
  Assumes inclusion by bare name from the table package and modules.
*/
`ifndef SMAT_REGS_SVH
`define SMAT_REGS_SVH

`define SMAT_ENTRIES 32
`define SMAT_IDX_W 5
`define SMAT_ADDR_W 48
`define SMAT_GID_W 7
`define SMAT_PORTS_W 5
// Indirect control codes
`define SMAT_CTL_READ 8'h10
`define SMAT_CTL_WRITE 8'h00
// Read image layout
`define SMAT_RD_GID_HI 63
`define SMAT_RD_GID_LO 57
`define SMAT_RD_USE 56
`define SMAT_RD_RSVD 55
// Write image layout
`define SMAT_WR_GID_HI 62
`define SMAT_WR_GID_LO 56
`define SMAT_WR_USE 55
// Common fields
`define SMAT_OVR 54
`define SMAT_VLD 53
`define SMAT_PM_HI 52
`define SMAT_PM_LO 48
`define SMAT_MAC_HI 47
`define SMAT_MAC_LO 0
// Reserved low port mask pattern and broadcast pattern
`define SMAT_PM_RSVD 5'h01
`define SMAT_PM_BCAST 5'h1f

`endif

// ===== rtl/smat_pkg.sv
/*
  Types for the static address table: stored entry, lookup request,
  and lookup answer. Assumes smat_regs.svh is on the include path.
*/
`include "smat_regs.svh"

package smat_pkg;

  // One stored table entry
  typedef struct packed {
    logic [`SMAT_GID_W-1:0] filter_group_id;
    logic group_match_enable;
    logic override;
    logic valid;
    logic [`SMAT_PORTS_W-1:0] port_mask;
    logic [`SMAT_ADDR_W-1:0] mac;
  } smat_entry_s;

  // Destination or source lookup request
  typedef struct packed {
    logic is_dest;
    logic [`SMAT_GID_W-1:0] filter_group_id;
    logic [`SMAT_ADDR_W-1:0] mac;
    logic [`SMAT_PORTS_W-1:0] ingress_mask;
  } smat_req_s;

  // Answer from the dynamic table
  typedef struct packed {
    logic hit;
    logic [`SMAT_PORTS_W-1:0] port_mask;
  } smat_dyn_s;

  // Final forwarding decision
  typedef struct packed {
    logic static_hit;
    logic hit;
    logic override;
    logic [`SMAT_PORTS_W-1:0] port_mask;
  } smat_fwd_s;

endpackage

// ===== rtl/smat_store.sv
/*
  Entry store for the static address table: registered entries with a
  single write port and a registered host read port. Matching needs
  every entry at once, so the entries are flattened out as well.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "smat_regs.svh"

module smat_store
  import smat_pkg::*;
#(
  parameter int ENTRIES = `SMAT_ENTRIES,
  parameter int IDX_W = `SMAT_IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input smat_pkg::smat_entry_s wr_data,
  // Registered read port
  input wire logic rd_en,
  input wire logic [IDX_W-1:0] rd_idx,
  output smat_pkg::smat_entry_s rd_data,
  // All entries for parallel matching
  output smat_pkg::smat_entry_s [ENTRIES-1:0] entries
);

  smat_entry_s mem_r [ENTRIES];
  smat_entry_s rd_data_r;

  // Entries change only by the write port, never by age
  genvar gi;
  for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_r[gi] <= '0;
      end else if (wr_en && wr_idx == IDX_W'(gi)) begin
        mem_r[gi] <= wr_data;
      end
    end
    assign entries[gi] = mem_r[gi];
  end

  // Host read data held in a register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= mem_r[rd_idx];
    end
  end

  assign rd_data = rd_data_r;

endmodule

// ===== rtl/smat_table.sv
/*
  Static destination address table of a small switch. Holds host
  programmed forwarding entries, matches destination lookups in one
  cycle and merges the answer with the dynamic table's result.
  Assumes the SPI transport decodes the indirect control, index and
  data bytes and presents them here as same-clock strobes; the
  dynamic table answer arrives in the same cycle as the request.
  Limitation: an index strobe always acts on the image as it stands, so
  a host that skips data bytes stores whatever they last held.
*/
`timescale 1ns/10ps
`include "smat_regs.svh"

// Notes on behaviour
// - Destination lookups search the static table and use the dynamic result.
// - Source lookups never search the static table; only dynamic applies.
// - A static hit wins over a dynamic hit for destinations.
// - Only the host command port can change entries.
// - Entries never age or vanish on their own.
// - Thirty-two entries; read and write images place fields differently.
// - Read image: group 63-57, use 56, reserved 55, override 54, valid 53.
// - Write image: group 62-56, use 55, override 54, valid 53, ports 52-48.
// - Use flag set matches group and address; clear matches address only.
// - Override lets forwarding pass spanning-tree port blocking.
// - Entries with valid clear take no part in matching.
// - Port mask selects ports; 11111 floods all but the ingress port.
// - Filter group identifier is seven bits, one of 128 groups.
// - Read: control 0x10, index write triggers, eight bytes out MSB first.
// - Write: load eight bytes, control 0x00, index write triggers store.
module smat_table
  import smat_pkg::*;
#(
  parameter int ENTRIES = `SMAT_ENTRIES,
  parameter int IDX_W = `SMAT_IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host indirect access strobes
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_data,
  input wire logic idx_wr,
  input wire logic [IDX_W-1:0] idx_data,
  input wire logic byte_wr,
  input wire logic [2:0] byte_sel,
  input wire logic [7:0] byte_data,
  input wire logic [2:0] rd_byte_sel,
  output logic [7:0] rd_byte,
  output logic rd_done,
  // Lookup request and dynamic table answer
  input wire logic lk_valid,
  input smat_pkg::smat_req_s lk_req,
  input smat_pkg::smat_dyn_s dyn_ans,
  // Forwarding decision
  output logic fwd_valid,
  output smat_pkg::smat_fwd_s fwd
);

  smat_entry_s [ENTRIES-1:0] entries;
  smat_entry_s rd_entry;
  smat_entry_s wr_entry;
  logic [63:0] wr_image_r;
  logic [63:0] rd_image;
  logic read_mode_r;
  logic rd_pend_r;
  logic wr_en;
  logic rd_en;
  logic [ENTRIES-1:0] hit_vec;
  smat_entry_s hit_ent;
  logic static_hit;
  logic fwd_valid_r;
  smat_fwd_s fwd_r;

  // Host data bytes, byte 0 carries bits 63-56
  // load image bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_image_r <= '0;
    end else if (byte_wr) begin
      wr_image_r[(7 - byte_sel) * 8 +: 8] <= byte_data;
    end
  end

  // Control register picks read or write
  // Any code other than the read code selects write
  // 0x10 selects read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_mode_r <= 1'b0;
    end else if (ctl_wr) begin
      read_mode_r <= (ctl_data == `SMAT_CTL_READ);
    end
  end

  // Index write is the trigger; other codes are not this table's
  // only host strobes write
  assign wr_en = idx_wr && !read_mode_r;
  assign rd_en = idx_wr && read_mode_r;

  // Unpack the write image
  // Bit 63 is dropped on write; the entry has no home for it
  // write layout
  always_comb begin
    wr_entry = '0;
    wr_entry.filter_group_id = wr_image_r[`SMAT_WR_GID_HI:`SMAT_WR_GID_LO];
    wr_entry.group_match_enable = wr_image_r[`SMAT_WR_USE];
    wr_entry.override = wr_image_r[`SMAT_OVR];
    wr_entry.valid = wr_image_r[`SMAT_VLD];
    wr_entry.port_mask = wr_image_r[`SMAT_PM_HI:`SMAT_PM_LO];
    wr_entry.mac = wr_image_r[`SMAT_MAC_HI:`SMAT_MAC_LO];
  end

  smat_store #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_store (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_idx(idx_data),
    .wr_data(wr_entry),
    .rd_en(rd_en),
    .rd_idx(idx_data),
    .rd_data(rd_entry),
    .entries(entries)
  );

  // Repack into the read image, reserved bit reads zero
  // read layout
  always_comb begin
    rd_image = '0;
    rd_image[`SMAT_RD_GID_HI:`SMAT_RD_GID_LO] = rd_entry.filter_group_id;
    rd_image[`SMAT_RD_USE] = rd_entry.group_match_enable;
    rd_image[`SMAT_OVR] = rd_entry.override;
    rd_image[`SMAT_VLD] = rd_entry.valid;
    rd_image[`SMAT_PM_HI:`SMAT_PM_LO] = rd_entry.port_mask;
    rd_image[`SMAT_MAC_HI:`SMAT_MAC_LO] = rd_entry.mac;
  end

  // Read data ready one cycle after the trigger
  // The store's read register is what costs that cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_en;
    end
  end

  assign rd_done = rd_pend_r;

  // Plain mux of the read register; bytes may be fetched in any order
  // bytes most significant first
  assign rd_byte = rd_image[(7 - rd_byte_sel) * 8 +: 8];

  // Parallel match across all entries
  // One comparator per entry costs area but answers every lookup in a cycle
  genvar gi;
  for (gi = 0; gi < ENTRIES; gi++) begin : g_match
    assign hit_vec[gi] = entries[gi].valid &&
                         entries[gi].mac == lk_req.mac &&
                         (!entries[gi].group_match_enable ||
                          entries[gi].filter_group_id == lk_req.filter_group_id);
  end

  // Lowest index wins if the host loaded duplicates
  // Duplicates are a host error; a fixed order keeps the answer stable
  always_comb begin
    hit_ent = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_ent = entries[i];
      end
    end
  end

  assign static_hit = lk_req.is_dest && (|hit_vec);

  // Registered forwarding decision
  // Held until the next lookup so a slow consumer can still read it
  // search both tables for destinations; sources use the dynamic table only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_r <= 1'b0;
      fwd_r <= '0;
    end else begin
      fwd_valid_r <= lk_valid;
      if (lk_valid) begin
        fwd_r.static_hit <= static_hit;
        if (static_hit) begin
          fwd_r.hit <= 1'b1;
          fwd_r.override <= hit_ent.override;
          if (hit_ent.port_mask == `SMAT_PM_BCAST) begin
            fwd_r.port_mask <= `SMAT_PM_BCAST & ~lk_req.ingress_mask;
          end else begin
            fwd_r.port_mask <= hit_ent.port_mask & ~`SMAT_PM_RSVD;
          end
        end else begin
          fwd_r.hit <= dyn_ans.hit;
          fwd_r.override <= 1'b0;
          fwd_r.port_mask <= dyn_ans.port_mask;
        end
      end
    end
  end

  assign fwd_valid = fwd_valid_r;
  assign fwd = fwd_r;

endmodule

// ===== sim/smat_table_chk.sv
/*
  Port checker for the static address table, bound into smat_table.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "smat_regs.svh"
module smat_table_chk
  import smat_pkg::*;
#(
  parameter int ENTRIES = `SMAT_ENTRIES,
  parameter int IDX_W = `SMAT_IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host access
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_data,
  input wire logic idx_wr,
  input wire logic [2:0] rd_byte_sel,
  input wire logic [7:0] rd_byte,
  input wire logic rd_done,
  // Lookup
  input wire logic lk_valid,
  input smat_pkg::smat_req_s lk_req,
  input smat_pkg::smat_dyn_s dyn_ans,
  input wire logic fwd_valid,
  input smat_pkg::smat_fwd_s fwd
);
  logic rd_mode_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Host mode; write after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mode_r <= 1'b0;
    end else if (ctl_wr) begin
      rd_mode_r <= (ctl_data == `SMAT_CTL_READ);
    end
  end
  // Lookup timing, precedence and fallback
  property p_lat; lk_valid |=> fwd_valid; endproperty
  a_lat: assert property (p_lat) else $error("lookup not answered");
  property p_ans; fwd_valid |-> $past(lk_valid); endproperty
  a_ans: assert property (p_ans) else $error("answer without lookup");
  property p_src;
    lk_valid && !lk_req.is_dest |=> fwd == {1'b0, $past(dyn_ans.hit), 1'b0,
      $past(dyn_ans.port_mask)};
  endproperty
  a_src: assert property (p_src) else $error("source lookup used static");
  property p_fb;
    lk_valid && lk_req.is_dest |=> fwd.static_hit || fwd == {1'b0,
      $past(dyn_ans.hit), 1'b0, $past(dyn_ans.port_mask)};
  endproperty
  a_fb: assert property (p_fb) else $error("bad dynamic fallback");
  property p_win; fwd_valid && fwd.static_hit |-> fwd.hit; endproperty
  a_win: assert property (p_win) else $error("static hit not a hit");
  property p_ovr; fwd_valid && !fwd.static_hit |-> !fwd.override; endproperty
  a_ovr: assert property (p_ovr) else $error("override without static");
  // Host read answer and read layout
  property p_rd; idx_wr && rd_mode_r |=> rd_done; endproperty
  a_rd: assert property (p_rd) else $error("read not done");
  property p_rsv; rd_byte_sel == 3'h1 |-> !rd_byte[7]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read bit set");
endmodule

bind smat_table smat_table_chk #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_chk (.sys_clk,
  .rst_n, .ctl_wr, .ctl_data, .idx_wr, .rd_byte_sel, .rd_byte, .rd_done, .lk_valid,
  .lk_req, .dyn_ans, .fwd_valid, .fwd);

// ===== sim/smat_host.sv
/*
  Host processor model that owns all static table entries.
  Assumes one clock; strobes launch on the falling edge.
*/
`timescale 1ns/10ps
`include "smat_regs.svh"
module smat_host (
  // Clock and read answer
  input wire logic sys_clk,
  input wire logic [7:0] rd_byte,
  input wire logic rd_done,
  // Indirect strobes
  output logic ctl_wr,
  output logic [7:0] ctl_data,
  output logic idx_wr,
  output logic [4:0] idx_data,
  output logic byte_wr,
  output logic [2:0] byte_sel,
  output logic [7:0] byte_data,
  output logic [2:0] rd_byte_sel
);
  // Idle from time zero
  initial {ctl_wr, ctl_data, idx_wr, idx_data, byte_wr, byte_sel, byte_data, rd_byte_sel} = '0;
  task automatic wr_entry(input logic [4:0] i, input logic [63:0] v);
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      {byte_wr, byte_sel, byte_data} = {1'b1, k[2:0], v[63-8*k -: 8]};
    end
    @(negedge sys_clk);
    // Released data turns to junk
    {byte_wr, byte_data, ctl_wr, ctl_data} = {1'b0, ~byte_data, 1'b1, `SMAT_CTL_WRITE};
    @(negedge sys_clk);
    {ctl_wr, idx_wr, idx_data} = {1'b0, 1'b1, i};
    @(negedge sys_clk);
    {idx_wr, idx_data} = {1'b0, ~i};
  endtask
  task automatic rd_entry(input logic [4:0] i, output logic [63:0] v, output logic done);
    @(negedge sys_clk);
    {ctl_wr, ctl_data} = {1'b1, `SMAT_CTL_READ};
    @(negedge sys_clk);
    {ctl_wr, idx_wr, idx_data} = {1'b0, 1'b1, i};
    @(negedge sys_clk);
    {idx_wr, idx_data} = {1'b0, ~i};
    done = rd_done;
    // One byte per cycle; the select moves only on falling edges
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      rd_byte_sel = k[2:0];
      #1;
      v[63-8*k -: 8] = rd_byte;
    end
  endtask
endmodule

// ===== sim/tb_top.sv
/*
  Bench for the static address table: host model edits entries,
  lookups are driven here. Assumes the host model and checker.
*/
`timescale 1ns/10ps
module tb_top;
  import smat_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctl_wr, idx_wr, byte_wr, rd_done, lk_valid, fwd_valid, dn;
  logic [7:0] ctl_data, byte_data, rd_byte;
  logic [4:0] idx_data;
  logic [2:0] byte_sel, rd_byte_sel;
  logic [63:0] rv;
  smat_req_s lk_req;
  smat_dyn_s dyn_ans;
  smat_fwd_s fwd;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam logic [47:0] MA = 48'h0a1b_2c3d_4e5f;
  localparam logic [47:0] MB = 48'h0a1b_2c3d_4e5e; // One bit off MA
  localparam logic [47:0] MC = 48'hfedc_ba98_7654;
  localparam logic [47:0] MD = 48'h8000_0000_0001;
  // Clock
  always #5 sys_clk = ~sys_clk;
  smat_table DUT (.sys_clk, .rst_n, .ctl_wr, .ctl_data, .idx_wr, .idx_data, .byte_wr,
    .byte_sel, .byte_data, .rd_byte_sel, .rd_byte, .rd_done, .lk_valid, .lk_req,
    .dyn_ans, .fwd_valid, .fwd);
  smat_host HOST (.sys_clk, .rd_byte, .rd_done, .ctl_wr, .ctl_data, .idx_wr,
    .idx_data, .byte_wr, .byte_sel, .byte_data, .rd_byte_sel);
  task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Store, then read back; uov is use, override, valid
  task wr_rd(input logic [4:0] i, input logic [6:0] g, input logic [2:0] uov,
             input logic [4:0] p, input logic [47:0] m);
    HOST.wr_entry(i, {1'b0, g, uov, p, m});
    HOST.rd_entry(i, rv, dn);
    chk("rd_done", dn, 1'b1);
    chk("entry", rv, {g, uov[2], 1'b0, uov[1:0], p, m});
  endtask
  // One lookup; e is static_hit, hit, override, ports
  task lk(input logic d, input logic [6:0] g, input logic [47:0] m, input logic [4:0] ing,
          input logic [5:0] dy, input logic [7:0] e);
    @(negedge sys_clk);
    {lk_valid, lk_req, dyn_ans} = {1'b1, d, g, m, ing, dy};
    @(negedge sys_clk);
    {lk_valid, dyn_ans} = {1'b0, ~dy};
    chk("fwd_valid", fwd_valid, 1'b1);
    chk("fwd", fwd, e);
  endtask
  // Hang guard, far above the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    {lk_valid, lk_req, dyn_ans} = '0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    lk(1'b1, 7'h00, MA, 5'h02, 6'h30, 8'h50);
    $display("test empty table done");
    wr_rd(5'h00, 7'h00, 3'h1, 5'h02, MA);
    wr_rd(5'h03, 7'h55, 3'h7, 5'h1f, MB);
    wr_rd(5'h05, 7'h12, 3'h2, 5'h04, MC);
    wr_rd(5'h1f, 7'h7f, 3'h1, 5'h07, MD);
    $display("test host access done");
    lk(1'b1, 7'h00, MA, 5'h04, 6'h30, 8'hc2);
    lk(1'b1, 7'h55, MB, 5'h04, 6'h00, 8'hfb);
    lk(1'b1, 7'h54, MB, 5'h04, 6'h28, 8'h48);
    lk(1'b1, 7'h00, MC, 5'h02, 6'h00, 8'h00);
    lk(1'b1, 7'h11, MD, 5'h02, 6'h21, 8'hc6);
    lk(1'b0, 7'h00, MA, 5'h02, 6'h30, 8'h50);
    $display("test lookup done");
    repeat (200) @(negedge sys_clk);
    lk(1'b1, 7'h00, MA, 5'h04, 6'h30, 8'hc2);
    wr_rd(5'h00, 7'h00, 3'h0, 5'h02, MA);
    lk(1'b1, 7'h00, MA, 5'h04, 6'h30, 8'h50);
    $display("test persist and delete done");
    end_of_test;
  end
endmodule
